// ===== hw/ppce_sync.sv
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module ppce_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // levels
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         meta <= '0;
         o_sync <= '0;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule
`default_nettype wire

// ===== hw/ppce_top.sv
// power path selection, adapter good deglitch and charge enable control
// What this block does
// - wake and enable host interface above lockout
// - start in low power; clearing enters performance
// - performance mode: features only when host enables
// - adapter detect above 0.6 V enables bias
// - adapter good needs supply, detect, margin
// - status bit mirrors adapter good pin
// - deglitch 150 ms first, 1.3 s later
// - overvoltage above 26 V: adapter off, battery
// - below 24 V: release, back to adapter
// - break-before-make; adapter and battery never together
// - battery switch needs supply, sense, adapter off
// - adapter selected when good and calibration allows
// - gate low after 20 ms: off, retry 1.3 s
// - seventh failure in 90 s latches off
// - adapter off when bad or calibration discharging
// - charge starts only when all conditions hold
// - charge stops on any listed fault
// - soft-start 128 mA, 64 mA per 400 us
// - discontinuous mode: larger, longer soft-start steps
// - input monitor valid above lockout and detect
// - calibration bit clears when cycle ends
`timescale 1ns/1ps
`default_nettype none
module ppce_top #(
   parameter int TICK_CYCLES_P = ppce_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // analog comparator results
   input wire ppce_pkg::ppce_cmp_t i_cmp,
   // host settings
   input wire logic i_opt_wr,
   input wire ppce_pkg::ppce_opt_t i_opt,
   input wire ppce_pkg::ppce_feat_t i_feat_req,
   input wire logic i_limits_valid,
   input wire logic i_watchdog_expired,
   input wire logic [ppce_pkg::CUR_W-1:0] i_charge_current_code,
   // power and status
   output logic o_awake,
   output logic o_bias_enable,
   output logic o_input_monitor_valid,
   output ppce_pkg::ppce_feat_t o_feature_en,
   output logic o_low_power,
   output logic o_cal_enable,
   // adapter good pin and status
   output logic o_adapter_good_output_o,
   output logic o_adapter_good_output_oe,
   output logic o_adapter_good_status,
   output logic o_adapter_overvoltage,
   // gate drives
   output logic o_adapter_gate_drive,
   output logic o_battery_gate_drive,
   output logic o_latched_off,
   output logic [2:0] o_fail_count,
   // charger
   output logic o_charge_enable,
   output logic [ppce_pkg::CUR_W-1:0] o_charge_current_target
);
   import ppce_pkg::*;

   function automatic logic [CUR_W-1:0] ppce_min(input logic [CUR_W-1:0] a,
                                                 input logic [CUR_W-1:0] b);
      return (a < b) ? a : b;
   endfunction

   // -----------------------------------------------------------------
   // synchronised comparators and time base
   // -----------------------------------------------------------------
   logic [$bits(ppce_cmp_t)-1:0] s_bits;
   ppce_cmp_t s;
   logic [PRE_W-1:0] pre_cnt;
   logic tick;

   ppce_sync #(.W($bits(ppce_cmp_t))) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_srst(i_srst),
      .i_async(i_cmp),
      .o_sync(s_bits)
   );
   assign s = ppce_cmp_t'(s_bits);

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         pre_cnt <= '0;
         tick <= 1'b0;
      end else if (pre_cnt == PRE_W'(TICK_CYCLES_P - 1)) begin
         pre_cnt <= '0;
         tick <= 1'b1;
      end else begin
         pre_cnt <= pre_cnt + 1'b1;
         tick <= 1'b0;
      end
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);

   // -----------------------------------------------------------------
   // options, power up and monitors
   // -----------------------------------------------------------------
   ppce_opt_t opt;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         opt <= OPT_RST;
      end else if (i_opt_wr) begin
         opt <= i_opt;
      end else if (opt.cal_enable && s.battery_below_depletion) begin
         opt.cal_enable <= 1'b0;
      end
   end
   assign o_low_power = opt.low_power;
   assign o_cal_enable = opt.cal_enable;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_awake <= 1'b0;
         o_bias_enable <= 1'b0;
         o_input_monitor_valid <= 1'b0;
         o_feature_en <= '0;
      end else begin
         o_awake <= s.supply_above_lockout;
         o_bias_enable <= s.detect_above_0p6v;
         o_input_monitor_valid <= s.supply_above_lockout
                                  & s.detect_above_0p6v;
         o_feature_en <= opt.low_power ? '0 : i_feat_req;
      end
   end

   chk_features_gated: assert property (
      opt.low_power |=> o_feature_en == '0)
      else $error("feature enabled in low power mode");
   chk_monitor_valid: assert property (
      o_input_monitor_valid |-> $past(s.detect_above_0p6v))
      else $error("input monitor valid without adapter detect");
   chk_cal_clear: assert property (
      opt.cal_enable && s.battery_below_depletion && !i_opt_wr
      |=> !opt.cal_enable)
      else $error("calibration bit not cleared at depletion");

   // -----------------------------------------------------------------
   // overvoltage and adapter good deglitch
   // -----------------------------------------------------------------
   logic ovp;
   logic adapter_good_output_raw;
   logic adapter_good_output;
   logic next_adapter_good_output;
   logic first_plug;
   logic [TICK_W-1:0] dg_cnt;
   logic [TICK_W-1:0] next_dg_cnt;
   logic [TICK_W-1:0] dg_limit;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         ovp <= 1'b0;
      end else if (s.supply_above_26v) begin
         ovp <= 1'b1;
      end else if (!s.supply_above_24v) begin
         ovp <= 1'b0;
      end
   end
   assign o_adapter_overvoltage = ovp;

   assign adapter_good_output_raw = s.supply_above_lockout & !ovp & !s.supply_above_26v
                     & s.detect_above_2p4v & s.supply_sense_margin_ok;
   assign dg_limit = first_plug ? TICK_W'(DEGLITCH_FIRST_TICKS)
                                : TICK_W'(DEGLITCH_NEXT_TICKS);

   always_comb begin
      next_adapter_good_output = adapter_good_output;
      next_dg_cnt = dg_cnt;
      if (!adapter_good_output_raw) begin
         next_adapter_good_output = 1'b0;
         next_dg_cnt = '0;
      end else if (!adapter_good_output && tick) begin
         next_dg_cnt = dg_cnt + 1'b1;
         if (dg_cnt == dg_limit - 1'b1) begin
            next_adapter_good_output = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         adapter_good_output <= 1'b0;
         dg_cnt <= '0;
         o_adapter_good_output_oe <= 1'b1;
         o_adapter_good_output_o <= 1'b0;
      end else begin
         adapter_good_output <= next_adapter_good_output;
         dg_cnt <= next_dg_cnt;
         o_adapter_good_output_oe <= !next_adapter_good_output;
         o_adapter_good_output_o <= 1'b0;
      end
   end
   assign o_adapter_good_status = adapter_good_output;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         first_plug <= 1'b1;
      end else if (!s.supply_above_lockout) begin
         first_plug <= 1'b1;
      end else if (adapter_good_output) begin
         first_plug <= 1'b0;
      end
   end

   chk_adapter_good_output_mirror: assert property (
      o_adapter_good_status == !o_adapter_good_output_oe)
      else $error("adapter good status differs from pin");
   chk_ovp_adapter_good_output_low: assert property (
      ovp |-> !o_adapter_good_status)
      else $error("adapter good released during overvoltage");

   // -----------------------------------------------------------------
   // power source selection
   // -----------------------------------------------------------------
   ppce_sel_t state;
   ppce_sel_t next_state;
   logic [TICK_W-1:0] sel_cnt;
   logic [TICK_W-1:0] next_sel_cnt;
   logic [TICK_W-1:0] win_cnt;
   logic [2:0] fail_cnt;
   logic win_run;
   logic want_ac;
   logic gate_fail;
   logic [BBM_W-1:0] ac_off_cnt;
   logic ac_off_done;

   // adapter is wanted unless calibration discharge keeps the battery
   assign want_ac = adapter_good_output & (!opt.cal_enable
                            | s.battery_below_depletion);
   assign gate_fail = (state == ST_AC_ON) && tick
                      && sel_cnt == TICK_W'(GATE_CHECK_TICKS - 1)
                      && !s.gate_above_5p7v;
   assign ac_off_done = ac_off_cnt == BBM_W'(BBM_CYCLES);

   always_comb begin
      next_state = state;
      next_sel_cnt = sel_cnt;
      unique case (state)
         ST_BAT: begin
            if (want_ac) begin
               next_state = ST_BRK;
               next_sel_cnt = '0;
            end
         end
         ST_BRK: begin
            next_sel_cnt = sel_cnt + 1'b1;
            if (!want_ac) begin
               next_state = ST_BAT;
            end else if (sel_cnt == TICK_W'(BBM_CYCLES - 1)) begin
               next_state = ST_AC_ON;
               next_sel_cnt = '0;
            end
         end
         ST_AC_ON: begin
            if (!want_ac) begin
               next_state = ST_BAT;
            end else if (gate_fail) begin
               next_sel_cnt = '0;
               if (fail_cnt == 3'(FAIL_LIMIT - 1)) begin
                  next_state = ST_LATCH;
               end else begin
                  next_state = ST_RETRY;
               end
            end else if (tick) begin
               if (sel_cnt == TICK_W'(GATE_CHECK_TICKS - 1)) begin
                  next_state = ST_AC_OK;
               end else begin
                  next_sel_cnt = sel_cnt + 1'b1;
               end
            end
         end
         ST_AC_OK: begin
            if (!want_ac) begin
               next_state = ST_BAT;
            end
         end
         ST_RETRY: begin
            if (tick) begin
               if (sel_cnt == TICK_W'(RETRY_TICKS - 1)) begin
                  next_state = ST_BAT;
               end else begin
                  next_sel_cnt = sel_cnt + 1'b1;
               end
            end
         end
         ST_LATCH: begin
            if (!s.detect_above_0p6v) begin
               next_state = ST_BAT;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         state <= ST_BAT;
         sel_cnt <= '0;
         o_adapter_gate_drive <= 1'b0;
         o_battery_gate_drive <= 1'b0;
         o_latched_off <= 1'b0;
      end else begin
         state <= next_state;
         sel_cnt <= next_sel_cnt;
         o_adapter_gate_drive <= next_state inside {ST_AC_ON, ST_AC_OK};
         o_battery_gate_drive <= (next_state inside {ST_BAT, ST_RETRY,
                                  ST_LATCH}) && ac_off_done
                                 && !o_adapter_gate_drive
                                 && s.supply_above_lockout
                                 && s.adapter_sense_within_200mv;
         o_latched_off <= next_state == ST_LATCH;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         ac_off_cnt <= '0;
      end else if (o_adapter_gate_drive) begin
         ac_off_cnt <= '0;
      end else if (!ac_off_done) begin
         ac_off_cnt <= ac_off_cnt + 1'b1;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         fail_cnt <= '0;
         win_cnt <= '0;
         win_run <= 1'b0;
      end else if (state == ST_LATCH && !s.detect_above_0p6v) begin
         fail_cnt <= '0;
         win_cnt <= '0;
         win_run <= 1'b0;
      end else if (gate_fail) begin
         fail_cnt <= fail_cnt + 1'b1;
         if (!win_run) begin
            win_run <= 1'b1;
            win_cnt <= '0;
         end
      end else if (win_run && state != ST_LATCH && tick) begin
         if (win_cnt == TICK_W'(FAIL_WINDOW_TICKS - 1)) begin
            win_run <= 1'b0;
            fail_cnt <= '0;
         end else begin
            win_cnt <= win_cnt + 1'b1;
         end
      end
   end
   assign o_fail_count = fail_cnt;

   sequence s_adapter_dropped;
      $fell(o_adapter_gate_drive);
   endsequence
   sequence s_gate_failed;
      gate_fail;
   endsequence

   chk_bbm_exclusive: assert property (
      !(o_adapter_gate_drive && o_battery_gate_drive))
      else $error("adapter and battery switches on together");
   chk_bbm_gap: assert property (
      s_adapter_dropped |-> !o_battery_gate_drive [*8])
      else $error("battery switch on without dead time");
   chk_battery_terms: assert property (
      o_battery_gate_drive |-> $past(s.adapter_sense_within_200mv)
                               && $past(s.supply_above_lockout))
      else $error("battery switch on without its conditions");
   chk_gate_retry: assert property (
      s_gate_failed |=> !o_adapter_gate_drive [*8])
      else $error("adapter switch not held off after gate failure");
   chk_latch_hold: assert property (
      state == ST_LATCH && s.detect_above_0p6v
      |=> state == ST_LATCH && !o_adapter_gate_drive)
      else $error("latch left without adapter detect reset");

   // -----------------------------------------------------------------
   // charge enable and soft-start
   // -----------------------------------------------------------------
   logic chg_fault;
   logic chg_start;
   logic chg_stop;
   logic next_chg;
   logic [SS_W-1:0] ss_cnt;
   logic [SS_W-1:0] ss_len;
   logic [CUR_W-1:0] ss_step;
   logic [CUR_W-1:0] target;

   assign chg_fault = s.battery_overvoltage | s.thermal_shutdown
                      | s.input_overcurrent | ovp;
   assign chg_start = !opt.charge_inhibit & s.current_limit_above_120mv
                      & i_limits_valid & adapter_good_output & (state == ST_AC_OK)
                      & !chg_fault & !s.short_circuit
                      & !i_watchdog_expired;
   assign chg_stop = opt.charge_inhibit | !s.current_limit_above_60mv
                     | !i_limits_valid | !adapter_good_output | (state != ST_AC_OK)
                     | chg_fault | s.short_circuit
                     | i_watchdog_expired;
   assign next_chg = !chg_stop & (chg_start | o_charge_enable);
   assign ss_len = s.discontinuous_mode ? SS_W'(SS_DCM_STEP_TICKS)
                                        : SS_W'(SS_CCM_STEP_TICKS);
   assign ss_step = s.discontinuous_mode ? SS_DCM_STEP_CODE
                                         : SS_CCM_STEP_CODE;

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_charge_enable <= 1'b0;
      end else begin
         o_charge_enable <= next_chg;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         target <= '0;
         ss_cnt <= '0;
      end else if (!next_chg) begin
         target <= '0;
         ss_cnt <= '0;
      end else if (!o_charge_enable) begin
         target <= ppce_min(SS_START_CODE, i_charge_current_code);
         ss_cnt <= '0;
      end else if (target > i_charge_current_code) begin
         target <= i_charge_current_code;
      end else if (target < i_charge_current_code && tick) begin
         if (ss_cnt >= ss_len - 1'b1) begin
            ss_cnt <= '0;
            target <= ppce_min(CUR_W'(target + ss_step),
                               i_charge_current_code);
         end else begin
            ss_cnt <= ss_cnt + 1'b1;
         end
      end
   end
   assign o_charge_current_target = target;

   chk_ovp_no_charge: assert property (
      ovp |=> !o_charge_enable)
      else $error("charging during adapter overvoltage");
   chk_softstart_start: assert property (
      $rose(o_charge_enable) |-> o_charge_current_target <= SS_START_CODE)
      else $error("soft-start began above its first step");
endmodule
`default_nettype wire

// ===== include/ppce_pkg.sv
// constants, states and signal bundles of the power path and charge enable block
package ppce_pkg;

   // -----------------------------------------------------------------
   // clock and time base
   // -----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int TICK_US = 100;
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
   localparam int PRE_W = 15;
   localparam int TICK_W = 20;

   // -----------------------------------------------------------------
   // delays, as printed, and their tick counts
   // -----------------------------------------------------------------
   localparam int DEGLITCH_FIRST_MS = 150;
   localparam int DEGLITCH_NEXT_MS = 1300;
   localparam int GATE_CHECK_MS = 20;
   localparam int RETRY_MS = 1300;
   localparam int FAIL_WINDOW_S = 90;
   localparam int SS_CCM_STEP_US = 400;
   localparam int SS_DCM_STEP_US = 800;
   localparam int BBM_NS = 100;
   localparam int DEGLITCH_FIRST_TICKS = DEGLITCH_FIRST_MS * 1000 / TICK_US;
   localparam int DEGLITCH_NEXT_TICKS = DEGLITCH_NEXT_MS * 1000 / TICK_US;
   localparam int GATE_CHECK_TICKS = GATE_CHECK_MS * 1000 / TICK_US;
   localparam int RETRY_TICKS = RETRY_MS * 1000 / TICK_US;
   localparam int FAIL_WINDOW_TICKS = FAIL_WINDOW_S * 1000000 / TICK_US;
   localparam int SS_CCM_STEP_TICKS = SS_CCM_STEP_US / TICK_US;
   localparam int SS_DCM_STEP_TICKS = SS_DCM_STEP_US / TICK_US;
   localparam int BBM_CYCLES = (BBM_NS * CLK_MHZ + 999) / 1000;
   localparam int FAIL_LIMIT = 7;
   localparam int SS_W = 4;
   localparam int BBM_W = 6;

   // -----------------------------------------------------------------
   // charge current codes, 64 mA per unit
   // -----------------------------------------------------------------
   localparam int CUR_W = 7;
   localparam logic [CUR_W-1:0] SS_START_CODE = 7'h02;
   localparam logic [CUR_W-1:0] SS_CCM_STEP_CODE = 7'h01;
   localparam logic [CUR_W-1:0] SS_DCM_STEP_CODE = 7'h02;

   // -----------------------------------------------------------------
   // bundles
   // -----------------------------------------------------------------
   typedef struct packed {
      logic supply_above_lockout;
      logic supply_above_26v;
      logic supply_above_24v;
      logic detect_above_0p6v;
      logic detect_above_2p4v;
      logic supply_sense_margin_ok;
      logic adapter_sense_within_200mv;
      logic gate_above_5p7v;
      logic battery_below_depletion;
      logic current_limit_above_120mv;
      logic current_limit_above_60mv;
      logic battery_overvoltage;
      logic thermal_shutdown;
      logic input_overcurrent;
      logic short_circuit;
      logic discontinuous_mode;
   } ppce_cmp_t;

   typedef struct packed {
      logic low_power;
      logic cal_enable;
      logic charge_inhibit;
   } ppce_opt_t;

   typedef struct packed {
      logic dischg_monitor;
      logic power_monitor;
      logic proc_hot;
      logic comparator;
   } ppce_feat_t;

   localparam ppce_opt_t OPT_RST = '{low_power: 1'b1, cal_enable: 1'b0,
                                     charge_inhibit: 1'b0};

   typedef enum logic [5:0] {
      ST_BAT   = 6'h01,
      ST_BRK   = 6'h02,
      ST_AC_ON = 6'h04,
      ST_AC_OK = 6'h08,
      ST_RETRY = 6'h10,
      ST_LATCH = 6'h20
   } ppce_sel_t;

endpackage

// ===== sim/ppce_analog.sv
// analog side model: comparator levels and adapter gate voltage
`timescale 1ns/1ps
`default_nettype none
module ppce_analog (
   // clock
   input wire logic i_clk_sys,
   // levels from the bench, drive from the block
   input wire ppce_pkg::ppce_cmp_t i_env,
   input wire logic i_gate_drive,
   input wire logic i_gate_fail,
   // comparator results
   output ppce_pkg::ppce_cmp_t o_cmp
);
   int rise;
   // gate voltage builds up some cycles after the drive turns on
   always_ff @(posedge i_clk_sys) begin
      rise <= (i_gate_drive && !i_gate_fail) ? rise + 1 : 0;
   end
   always_comb begin
      o_cmp = i_env;
      o_cmp.gate_above_5p7v = rise > 10;
   end
endmodule
`default_nettype wire

// ===== sim/ppce_top_tb.sv
// self-checking bench of the power path and charge enable block
`timescale 1ns/1ps
`default_nettype none
module ppce_top_tb;
   import ppce_pkg::*;
   // ----
   // signals
   // ----
   localparam int TK = 2;
   logic i_clk_sys, i_srst, i_opt_wr, i_limits_valid, i_watchdog_expired;
   logic o_awake, o_bias_enable, o_input_monitor_valid, o_low_power;
   logic o_cal_enable, o_adapter_good_output_o, o_adapter_good_output_oe;
   logic o_adapter_good_status, o_adapter_overvoltage, o_adapter_gate_drive;
   logic o_battery_gate_drive, o_latched_off, o_charge_enable, gate_fail;
   logic [2:0] o_fail_count;
   logic [CUR_W-1:0] i_charge_current_code, o_charge_current_target;
   ppce_cmp_t env, good, i_cmp;
   ppce_opt_t i_opt;
   ppce_feat_t i_feat_req, o_feature_en;
   int miscompares, checks_done, n, k, e, last, dead;
   ppce_analog ana_u (.i_clk_sys, .i_env(env),
      .i_gate_drive(o_adapter_gate_drive), .i_gate_fail(gate_fail),
      .o_cmp(i_cmp));
   ppce_top #(.TICK_CYCLES_P(TK)) dut_u (.i_clk_sys, .i_srst, .i_cmp,
      .i_opt_wr, .i_opt, .i_feat_req, .i_limits_valid, .i_watchdog_expired,
      .i_charge_current_code, .o_awake, .o_bias_enable,
      .o_input_monitor_valid, .o_feature_en, .o_low_power, .o_cal_enable,
      .o_adapter_good_output_o, .o_adapter_good_output_oe,
      .o_adapter_good_status, .o_adapter_overvoltage, .o_adapter_gate_drive,
      .o_battery_gate_drive, .o_latched_off, .o_fail_count,
      .o_charge_enable, .o_charge_current_target);
   initial begin
      i_clk_sys = 0;
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end
   // adapter pair only after the battery switch has been off a dead time
   always @(negedge i_clk_sys) begin
      dead = o_battery_gate_drive ? 0 : dead + 1;
      if (o_adapter_gate_drive && dead < BBM_CYCLES - 1) chk("bbm", 0, 1);
   end
   // ----
   // tasks
   // ----
   task automatic chk(input string nm, input logic [7:0] x,
                      input logic [7:0] g);
      checks_done++;
      if (g !== x) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(negedge i_clk_sys);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic await(ref logic s, input int lim);
      for (n = 0; n < lim && s !== 1'b1; n++) cyc(1);
      if (n == lim) begin
         chk("timeout", 1, 0);
         conclude();
      end
   endtask
   task automatic wopt(input logic l, input logic c, input logic h);
      i_opt = '{low_power: l, cal_enable: c, charge_inhibit: h};
      i_opt_wr = 1;
      cyc(1);
      i_opt_wr = 0;
   endtask
   // ----
   // tests
   // ----
   initial begin
      {i_srst, i_opt_wr, i_limits_valid, i_watchdog_expired} = 4'h8;
      {env, i_opt, i_feat_req, i_charge_current_code, gate_fail} = '0;
      void'($urandom(34));
      cyc(6);
      i_srst = 0;
      chk("low_power", 1, o_low_power);
      chk("good_oe", 1, o_adapter_good_output_oe);
      chk("good_o", 0, o_adapter_good_output_o);
      chk("status", 0, o_adapter_good_status);
      i_feat_req = 4'($urandom);
      cyc(3);
      chk("feat_lp", 0, o_feature_en);
      wopt(0, 0, 0);
      cyc(2);
      chk("low_power", 0, o_low_power);
      chk("feat", i_feat_req, o_feature_en);
      env.supply_above_lockout = 1;
      cyc(1);
      chk("awake_sync", 0, o_awake);
      cyc(3);
      chk("awake", 1, o_awake);
      chk("mon_valid", 0, o_input_monitor_valid);
      env.detect_above_0p6v = 1;
      env.adapter_sense_within_200mv = 1;
      // battery switch also waits out the dead time counted from reset
      cyc(12);
      chk("bias", 1, o_bias_enable);
      chk("mon_valid", 1, o_input_monitor_valid);
      chk("bat_drive", 1, o_battery_gate_drive);
      $display("test power up done");
      env.detect_above_2p4v = 1;
      env.supply_sense_margin_ok = 1;
      await(o_adapter_good_status, 4000);
      chk("deglitch1", 1, n > 2990 && n < 3020);
      chk("good_oe", 0, o_adapter_good_output_oe);
      await(o_adapter_gate_drive, 100);
      chk("bat_drive", 0, o_battery_gate_drive);
      cyc(450);
      chk("gate_ok", 1, o_adapter_gate_drive);
      $display("test adapter done");
      i_charge_current_code = 7'(4 + $urandom % 20);
      i_limits_valid = 1;
      env.current_limit_above_120mv = 1;
      env.current_limit_above_60mv = 1;
      good = env;
      await(o_charge_enable, 20);
      chk("ss_start", 2, o_charge_current_target);
      e = 2;
      for (k = 0; k < 1000 && e < i_charge_current_code; k++) begin
         cyc(1);
         if (o_charge_current_target !== 7'(e)) begin
            e++;
            chk("ss_step", 8'(e), o_charge_current_target);
            if (e > 3) chk("ss_gap", 8'(4 * TK), 8'(k - last));
            last = k;
         end
      end
      cyc(20);
      chk("ss_clamp", i_charge_current_code, o_charge_current_target);
      env.current_limit_above_120mv = 0;
      cyc(5);
      chk("chg_hold", 1, o_charge_enable);
      env.current_limit_above_60mv = 0;
      cyc(5);
      chk("chg_current_limit_input", 0, o_charge_enable);
      for (k = 0; k < 7; k++) begin
         env = good;
         wopt(0, 0, 0);
         i_watchdog_expired = 0;
         i_limits_valid = 1;
         await(o_charge_enable, 40);
         case (k)
            0: i_watchdog_expired = 1;
            1: i_limits_valid = 0;
            2: env.battery_overvoltage = 1;
            3: env.thermal_shutdown = 1;
            4: env.input_overcurrent = 1;
            5: env.short_circuit = 1;
            default: wopt(0, 0, 1);
         endcase
         cyc(5);
         chk("chg_stop", 0, o_charge_enable);
      end
      env = good;
      env.discontinuous_mode = 1;
      wopt(0, 0, 0);
      await(o_charge_enable, 40);
      for (k = 0; k < 100 && o_charge_current_target === 7'h02; k++) cyc(1);
      chk("dcm_step", 4, o_charge_current_target);
      chk("dcm_len", 1, k > 4 * TK);
      $display("test charge done");
      wopt(0, 1, 0);
      cyc(30);
      chk("cal_ac", 0, o_adapter_gate_drive);
      chk("cal_bat", 1, o_battery_gate_drive);
      env.battery_below_depletion = 1;
      await(o_adapter_gate_drive, 100);
      chk("cal_clr", 0, o_cal_enable);
      chk("cal_bat", 0, o_battery_gate_drive);
      $display("test calibration done");
      // charge must be running so that overvoltage has something to stop
      await(o_charge_enable, 500);
      env.supply_above_24v = 1;
      env.supply_above_26v = 1;
      cyc(5);
      chk("ovp", 1, o_adapter_overvoltage);
      chk("ovp_oe", 1, o_adapter_good_output_oe);
      chk("ovp_ac", 0, o_adapter_gate_drive);
      chk("ovp_chg", 0, o_charge_enable);
      cyc(30);
      chk("ovp_bat", 1, o_battery_gate_drive);
      env.supply_above_26v = 0;
      cyc(5);
      chk("ovp_hyst", 1, o_adapter_overvoltage);
      env.supply_above_24v = 0;
      gate_fail = 1;
      cyc(5);
      chk("ovp_clr", 0, o_adapter_overvoltage);
      await(o_adapter_gate_drive, 27000);
      chk("deglitch2", 1, n > 25900);
      chk("ret_bat", 0, o_battery_gate_drive);
      cyc(450);
      chk("gate_fail", 0, o_adapter_gate_drive);
      chk("fail_cnt", 1, o_fail_count);
      gate_fail = 0;
      await(o_adapter_gate_drive, 27000);
      chk("retry", 1, n > 25500);
      chk("fail_keep", 1, o_fail_count);
      chk("latched", 0, o_latched_off);
      $display("test overvoltage done");
      conclude();
   end
endmodule
`default_nettype wire
